// >>> hdl/driver_mode_reset_control.sv
`timescale 1ns/1ps
`default_nettype none
module driver_mode_reset_control (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_logic_supply_ok,
   input wire logic i_load_supply_ok,
   input wire logic i_en,
   input wire logic i_frame_sel_n,
   input wire logic i_cfg_we,
   input wire logic [7:0] i_cfg_wdata,
   input wire logic i_flag_set,
   input wire logic i_sdo_data,
   output logic o_normal_mode,
   output logic o_charge_pump_en,
   output logic o_outputs_en,
   output logic o_standby,
   output logic o_regs_clear,
   output logic o_serial_enable,
   output logic [7:0] o_cfg,
   output logic o_reset_indication_flag,
   output logic o_frame_gap_err,
   output logic o_sdo,
   output logic o_sdo_oe
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic vdd_ok, vs_ok, en_s, sel_n_s;
   sync2 u_sync_vdd (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_async(i_logic_supply_ok),
      .o_sync(vdd_ok));
   sync2 u_sync_vs (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_async(i_load_supply_ok),
      .o_sync(vs_ok));
   // Synchroniser resets low, so enable reads as sleep until two clocks after reset
   sync2 u_sync_en (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_async(i_en),
      .o_sync(en_s));
   logic sel_raw_s;
   sync2 u_sync_sel (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_async(i_frame_sel_n),
      .o_sync(sel_raw_s));
   assign sel_n_s = sel_raw_s;

   // ----------------------------------------
   // Mode state machine
   // ----------------------------------------
   drv_mode_pkg::mode_t state_q, state_d;
   logic [11:0] cnt_q;
   logic en_q;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         en_q <= 1'b0;
      end else begin
         en_q <= en_s;
      end
   end
   always_comb begin
      state_d = state_q;
      case (state_q)
         drv_mode_pkg::ST_OFF: begin
            if (vdd_ok) begin
               state_d = drv_mode_pkg::ST_INIT;
            end
         end
         drv_mode_pkg::ST_INIT: begin
            if (!vdd_ok) begin
               state_d = drv_mode_pkg::ST_OFF;
            end else if (cnt_q == 12'(drv_mode_pkg::SETTLE_CYCLES - 1)) begin
               state_d = en_s ? drv_mode_pkg::ST_NORMAL : drv_mode_pkg::ST_SLEEP;
            end
         end
         drv_mode_pkg::ST_NORMAL: begin
            if (!vdd_ok) begin
               state_d = drv_mode_pkg::ST_OFF;
            end else if (!en_s) begin
               state_d = drv_mode_pkg::ST_SLEEP;
            end
         end
         drv_mode_pkg::ST_SLEEP: begin
            if (!vdd_ok) begin
               state_d = drv_mode_pkg::ST_OFF;
            end else if (en_s) begin
               state_d = drv_mode_pkg::ST_NORMAL;
            end
         end
         default: state_d = drv_mode_pkg::ST_OFF;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= drv_mode_pkg::ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= 12'h000;
      end else if (state_q != state_d) begin
         cnt_q <= 12'h000;
      end else if (cnt_q != 12'hFFF) begin
         cnt_q <= cnt_q + 12'h001;
      end
   end

   // ----------------------------------------
   // Mode outputs
   // ----------------------------------------
   // Load supply gates only the drive stage; stored state is never touched by it
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_normal_mode <= 1'b0;
         o_charge_pump_en <= 1'b0;
         o_outputs_en <= 1'b0;
         o_serial_enable <= 1'b0;
         o_regs_clear <= 1'b1;
      end else begin
         o_normal_mode <= (state_d == drv_mode_pkg::ST_NORMAL);
         o_charge_pump_en <= (state_d == drv_mode_pkg::ST_NORMAL);
         o_outputs_en <= (state_d == drv_mode_pkg::ST_NORMAL) && vs_ok;
         o_serial_enable <= (state_d == drv_mode_pkg::ST_NORMAL) ||
            (state_d == drv_mode_pkg::ST_SLEEP);
         o_regs_clear <= (state_d != drv_mode_pkg::ST_NORMAL);
      end
   end

   // Standby asserts on the same edge as sleep entry, far inside the 8 us limit
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_standby <= 1'b1;
      end else begin
         o_standby <= (state_d == drv_mode_pkg::ST_SLEEP) ||
            (state_d == drv_mode_pkg::ST_OFF);
      end
   end

   // ----------------------------------------
   // Configuration storage
   // ----------------------------------------
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cfg <= drv_mode_pkg::CFG_RESET;
      end else if (state_d != drv_mode_pkg::ST_NORMAL) begin
         o_cfg <= drv_mode_pkg::CFG_RESET;
      end else if (i_cfg_we && !sel_n_s) begin
         o_cfg <= i_cfg_wdata;
      end
   end

   // ----------------------------------------
   // Reset indication flag
   // ----------------------------------------
   // Reads 0 after any reset; a later set from the host wins only once back in normal mode
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_reset_indication_flag <= drv_mode_pkg::RST_FLAG_RESET;
      end else if (state_q != drv_mode_pkg::ST_NORMAL) begin
         o_reset_indication_flag <= drv_mode_pkg::RST_FLAG_RESET;
      end else if (i_flag_set) begin
         o_reset_indication_flag <= 1'b1;
      end
   end

   // ----------------------------------------
   // Frame gap monitor and serial output
   // ----------------------------------------
   logic [11:0] gap_q;
   logic sel_n_q;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sel_n_q <= 1'b1;
         gap_q <= 12'hFFF;
         o_frame_gap_err <= 1'b0;
      end else begin
         sel_n_q <= sel_n_s;
         if (sel_n_s && !sel_n_q) begin
            gap_q <= 12'h000;
         end else if (sel_n_s && gap_q != 12'hFFF) begin
            gap_q <= gap_q + 12'h001;
         end
         // Diagnostic only: the host owns this spacing
         o_frame_gap_err <= !sel_n_s && sel_n_q &&
            (gap_q < 12'(drv_mode_pkg::FRAME_GAP_CYCLES));
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_sdo <= 1'b0;
         o_sdo_oe <= 1'b0;
      end else begin
         o_sdo_oe <= !sel_n_s && vdd_ok;
         o_sdo <= i_sdo_data;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/drv_mode_pkg.sv
package drv_mode_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned STANDBY_ENTRY_DELAY_US = 8;
   localparam int unsigned STANDBY_ENTRY_CYCLES = STANDBY_ENTRY_DELAY_US * CLK_MHZ;
   localparam int unsigned FRAME_GAP_TIME_US = 5;
   localparam int unsigned FRAME_GAP_CYCLES = FRAME_GAP_TIME_US * CLK_MHZ;
   localparam int unsigned SETTLE_CYCLES = 4;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic RST_FLAG_RESET = 1'b0;
   localparam logic [7:0] CFG_RESET = 8'h00;
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_INIT = 2'b01,
      ST_NORMAL = 2'b10,
      ST_SLEEP = 2'b11
   } mode_t;
endpackage

// >>> hdl/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_async,
   output logic o_sync
);
   logic meta_q;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_q <= 1'b0;
         o_sync <= 1'b0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule
`default_nettype wire

// >>> tb/driver_mode_reset_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module driver_mode_reset_control_asserts (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_logic_supply_ok,
   input wire logic i_load_supply_ok,
   input wire logic i_en,
   input wire logic i_frame_sel_n,
   input wire logic o_normal_mode,
   input wire logic o_charge_pump_en,
   input wire logic o_outputs_en,
   input wire logic o_standby,
   input wire logic o_regs_clear,
   input wire logic o_serial_enable,
   input wire logic [7:0] o_cfg,
   input wire logic o_reset_indication_flag,
   input wire logic o_sdo_oe
);
   // ----
   // Mode checks; bounds allow the two-flop input sync
   // ----
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   power_on_a: assert property ($rose(o_serial_enable) |-> o_cfg == 8'h00 && !$past(o_outputs_en))
      else $error("power-on state not clear");
   load_drop_a: assert property ((i_en && i_logic_supply_ok)[*4] ##0 (o_normal_mode && !i_load_supply_ok) |=> o_normal_mode)
      else $error("mode lost on load drop");
   normal_pump_a: assert property (o_normal_mode |-> o_charge_pump_en && o_serial_enable && !o_standby)
      else $error("normal mode outputs wrong");
   sleep_clear_a: assert property (!o_normal_mode [*2] |-> o_regs_clear && !o_outputs_en && o_cfg == 8'h00)
      else $error("sleep state not clear");
   standby_time_a: assert property ($fell(i_en) |-> ##[1:5] o_standby)
      else $error("standby late");
   supply_low_a: assert property ($fell(i_logic_supply_ok) |-> ##[1:5] (!o_serial_enable && !o_outputs_en && o_cfg == 8'h00))
      else $error("supply loss not handled");
   flag_zero_a: assert property ($rose(o_normal_mode) |-> !o_reset_indication_flag)
      else $error("flag set on entry");
   sdo_idle_a: assert property (i_frame_sel_n [*4] |-> !o_sdo_oe)
      else $error("sdo driven outside frame");
   cover property ($fell(o_normal_mode));
   cover property ($rose(o_reset_indication_flag));
   cover property ($fell(o_serial_enable));
endmodule
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic i_core_clk,
   output logic o_en,
   output logic o_frame_sel_n,
   output logic o_cfg_we,
   output logic [7:0] o_cfg_wdata,
   output logic o_flag_set
);
   // ----
   // Host pins, changed on falling edges only
   // ----
   int gap_q = 0;
   initial begin
      o_en = 1'b0;
      o_frame_sel_n = 1'b1;
      o_cfg_we = 1'b0;
      o_cfg_wdata = 8'h00;
      o_flag_set = 1'b0;
   end
   always @(posedge i_core_clk) gap_q <= o_frame_sel_n ? gap_q + 1 : 0;
   task automatic open_frame;
      while (gap_q < drv_mode_pkg::FRAME_GAP_CYCLES) @(negedge i_core_clk);
      o_frame_sel_n = 1'b0;
   endtask
   // Data is inverted after the strobe so a late sample cannot pass
   task automatic write(input logic [7:0] d);
      o_cfg_we = 1'b1;
      o_cfg_wdata = d;
      o_flag_set = 1'b1;
      @(negedge i_core_clk);
      o_cfg_we = 1'b0;
      o_flag_set = 1'b0;
      o_cfg_wdata = ~d;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_driver_mode_reset_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_driver_mode_reset_control;
   logic i_core_clk, i_nrst, i_logic_supply_ok, i_load_supply_ok, i_en, i_frame_sel_n;
   logic i_cfg_we, i_flag_set, i_sdo_data, o_normal_mode, o_charge_pump_en, o_outputs_en;
   logic o_standby, o_regs_clear, o_serial_enable, o_reset_indication_flag, o_sdo, o_sdo_oe;
   logic o_frame_gap_err;
   logic [7:0] i_cfg_wdata, o_cfg;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   host_model u_host_model (.i_core_clk, .o_en(i_en), .o_frame_sel_n(i_frame_sel_n),
      .o_cfg_we(i_cfg_we), .o_cfg_wdata(i_cfg_wdata), .o_flag_set(i_flag_set));
   driver_mode_reset_control u_driver_mode_reset_control (.i_core_clk, .i_nrst,
      .i_logic_supply_ok, .i_load_supply_ok, .i_en, .i_frame_sel_n, .i_cfg_we, .i_cfg_wdata,
      .i_flag_set, .i_sdo_data, .o_normal_mode, .o_charge_pump_en, .o_outputs_en, .o_standby,
      .o_regs_clear, .o_serial_enable, .o_cfg, .o_reset_indication_flag, .o_frame_gap_err,
      .o_sdo, .o_sdo_oe);
   // ----
   // Shared tasks
   // ----
   initial begin
      i_core_clk = 1'b0;
      forever #2 i_core_clk = ~i_core_clk;
   end
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         $display("FAIL %0t timeout", $time);
         end_of_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %0t %s", $time, what);
      end
   endtask
   task automatic wait_normal;
      for (int i = 0; i < 40 && o_normal_mode !== 1'b1; i++) @(negedge i_core_clk);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----
   // Scenarios
   // ----
   task automatic power_up;
      i_logic_supply_ok = 1'b1;
      u_host_model.o_en = 1'b1;
      wait_normal();
      chk(8'(o_charge_pump_en), 8'h01, "pump");
      chk(o_cfg, 8'h00, "cfg at power-on");
      chk(8'(o_reset_indication_flag), 8'h00, "flag at power-on");
   endtask
   task automatic frame_write;
      u_host_model.open_frame();
      repeat (4) @(negedge i_core_clk);
      u_host_model.write(8'hA5);
      repeat (3) @(negedge i_core_clk);
      chk(8'({o_sdo_oe, o_sdo}), 8'h03, "sdo in frame");
      chk(o_cfg, 8'hA5, "cfg write");
      u_host_model.o_frame_sel_n = 1'b1;
      repeat (4) @(negedge i_core_clk);
      chk(8'(o_sdo_oe), 8'h00, "sdo after frame");
   endtask
   // Deliberately reopens a frame too early to exercise the gap diagnostic
   task automatic gap_short;
      u_host_model.o_frame_sel_n = 1'b0;
      repeat (3) @(negedge i_core_clk);
      chk(8'(o_frame_gap_err), 8'h01, "gap error pulse");
      u_host_model.o_frame_sel_n = 1'b1;
      @(negedge i_core_clk);
      chk(8'(o_frame_gap_err), 8'h00, "gap error one cycle");
   endtask
   task automatic load_drop;
      i_load_supply_ok = 1'b0;
      repeat (4) @(negedge i_core_clk);
      chk(8'({o_normal_mode, o_outputs_en}), 8'h02, "mode on load drop");
      i_load_supply_ok = 1'b1;
      repeat (4) @(negedge i_core_clk);
      chk(o_cfg, 8'hA5, "cfg kept");
      chk(8'(o_outputs_en), 8'h01, "outputs back");
   endtask
   task automatic en_sleep;
      u_host_model.o_en = 1'b0;
      repeat (4) @(negedge i_core_clk);
      chk(8'({o_standby, o_outputs_en}), 8'h02, "standby");
      chk(o_cfg, 8'h00, "cfg in sleep");
      u_host_model.o_en = 1'b1;
      wait_normal();
      chk(8'(o_reset_indication_flag), 8'h00, "flag after sleep");
   endtask
   task automatic supply_drop;
      frame_write();
      i_logic_supply_ok = 1'b0;
      repeat (5) @(negedge i_core_clk);
      chk(8'({o_serial_enable, o_outputs_en}), 8'h00, "supply off");
      chk(o_cfg, 8'h00, "cfg on supply loss");
      i_logic_supply_ok = 1'b1;
      wait_normal();
      chk(8'(o_reset_indication_flag), 8'h00, "flag after supply");
   endtask
   initial begin
      i_nrst = 1'b0;
      i_logic_supply_ok = 1'b0;
      i_load_supply_ok = 1'b1;
      i_sdo_data = 1'b1;
      repeat (6) @(negedge i_core_clk);
      i_nrst = 1'b1;
      power_up();
      frame_write();
      gap_short();
      load_drop();
      en_sleep();
      supply_drop();
      end_of_test();
   end
endmodule
bind driver_mode_reset_control driver_mode_reset_control_asserts u_chk (.i_core_clk, .i_nrst,
   .i_logic_supply_ok, .i_load_supply_ok, .i_en, .i_frame_sel_n, .o_normal_mode,
   .o_charge_pump_en, .o_outputs_en, .o_standby, .o_regs_clear, .o_serial_enable, .o_cfg,
   .o_reset_indication_flag, .o_sdo_oe);
`default_nettype wire
